/* File: rtl/boot_pkg.sv */
`default_nettype none
package boot_pkg;
	localparam int CLK_FREQ_MHZ = 200;
	localparam int CHARGE_MIN_NS = 7000;
	localparam int FAULT_TIMEOUT_US = 200;
	// Least time rounds up, longest time rounds down
	localparam int CHARGE_MIN_CYC = (CHARGE_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int FAULT_TIMEOUT_CYC = FAULT_TIMEOUT_US * CLK_FREQ_MHZ;
	localparam int CNT_W = 16;
	localparam int PHASES = 3;

	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] MASK_ADDR = 4'h8;
	localparam logic [3:0] STATE_ADDR = 4'hC;
	localparam int ADDR_LSBS = 4;

	localparam int MANAGE_OFF_BIT = 0;
	localparam int STATE_FORCE_LSB = 3;
	localparam logic CTRL_RST = 1'b0;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b01,
		PH_CHARGE = 2'b10
	} phase_state_t;

	typedef struct packed {
		logic hs;
		logic ls;
	} gate_pair_t;
endpackage
`default_nettype wire

/* File: rtl/boot_phase.sv */
`default_nettype none
module boot_phase #(
	parameter int TIMEOUT_CYC = 40000
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic below_uv_i,
	input wire logic above_hys_i,
	input wire logic manage_off_i,
	output logic charging_o,
	output logic force_o,
	output logic fault_o,
	output logic [boot_pkg::CNT_W-1:0] cnt_o
);
	import boot_pkg::*;
	phase_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q;
	logic fault_q;
	wire min_done = cnt_q >= CNT_W'(CHARGE_MIN_CYC - 1);
	wire at_timeout = cnt_q == CNT_W'(TIMEOUT_CYC - 1);
	wire cnt_sat = &cnt_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PH_IDLE: if (below_uv_i) state_d = PH_CHARGE;
			PH_CHARGE: if (above_hys_i && min_done) state_d = PH_IDLE;
			default: state_d = PH_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= PH_IDLE;
			cnt_q <= '0;
			fault_q <= 1'b0;
		end else begin
			state_q <= state_d;
			// Saturate so a stuck-low capacitor faults only once per interval
			cnt_q <= (state_q != PH_CHARGE) ? '0 : cnt_q + CNT_W'(!cnt_sat);
			fault_q <= (state_q == PH_CHARGE) && at_timeout && !above_hys_i;
		end
	end

	assign charging_o = state_q == PH_CHARGE;
	// Monitor keeps running while disabled, only the drive is dropped
	assign force_o = charging_o && !manage_off_i;
	assign fault_o = fault_q;
	assign cnt_o = cnt_q;
endmodule // boot_phase
`default_nettype wire

/* File: rtl/bootstrap_charge_manager.sv */
// Operation
// - Each phase's bootstrap voltage is watched on its own against the threshold.
// - Below threshold with management on, force low-side until above threshold plus hysteresis.
// - Each forced recharge lasts at least the 7 us minimum charge time.
// - No recovery within 200 us of charging flags that phase's bootstrap fault.
// - Management off stops forcing but monitoring and fault reports continue.
// - One control bit: 0 keeps management active and is default, 1 disables.
// - Faults for phases A, B, C are separate flags, each with a mask.
// - All block timing counts cycles of the system clock.
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
module bootstrap_charge_manager #(
	parameter int FAULT_TIMEOUT_CYC = boot_pkg::FAULT_TIMEOUT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic [2:0] below_uv_i,
	input wire logic [2:0] above_hys_i,
	input wire boot_pkg::gate_pair_t [2:0] gate_cmd_i,
	output boot_pkg::gate_pair_t [2:0] gate_drv_o,
	output logic irq_o
);
	import boot_pkg::*;

	logic boot_manage_off_q;
	logic [2:0] status_q, mask_q;
	logic wr_pend_q, hready_q, hresp_q, irq_q;
	logic [ADDR_LSBS-1:0] wr_addr_q;
	logic [31:0] hrdata_q;
	gate_pair_t [2:0] gate_q;
	logic [2:0] charging_w, force_w, fault_w;
	logic [CNT_W-1:0] cnt_w [PHASES];

	for (genvar p = 0; p < PHASES; p++) begin : g_phase
		boot_phase #(.TIMEOUT_CYC(FAULT_TIMEOUT_CYC)) u_phase (
			.clk_sys_i(clk_sys_i),
			.rst_n_i(rst_n_i),
			.below_uv_i(below_uv_i[p]),
			.above_hys_i(above_hys_i[p]),
			.manage_off_i(boot_manage_off_q),
			.charging_o(charging_w[p]),
			.force_o(force_w[p]),
			.fault_o(fault_w[p]),
			.cnt_o(cnt_w[p])
		);
	end

	// Bus decode: zero wait states, read data latched in the address phase
	wire addr_ok = hsel_i && htrans_i[1] && hready_i;
	wire rd_req = addr_ok && !hwrite_i;
	wire wr_req = addr_ok && hwrite_i;
	wire [ADDR_LSBS-1:0] rd_addr = haddr_i[ADDR_LSBS-1:0];
	wire wr_ctrl = wr_pend_q && wr_addr_q == CTRL_ADDR;
	wire wr_status = wr_pend_q && wr_addr_q == STATUS_ADDR;
	wire wr_mask = wr_pend_q && wr_addr_q == MASK_ADDR;
	wire [2:0] status_clr = wr_status ? hwdata_i[2:0] : 3'h0;
	// Set wins over a clear in the same cycle
	wire [2:0] status_d = (status_q & ~status_clr) | fault_w;
	wire [31:0] state_word = {26'h0, force_w, charging_w};
	wire [31:0] rd_mux =
		rd_addr == CTRL_ADDR ? {31'h0, boot_manage_off_q} :
		rd_addr == STATUS_ADDR ? {29'h0, status_q} :
		rd_addr == MASK_ADDR ? {29'h0, mask_q} :
		rd_addr == STATE_ADDR ? state_word : 32'h0;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q <= 32'h0;
			hready_q <= 1'b0;
			hresp_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_req;
			wr_addr_q <= wr_req ? haddr_i[ADDR_LSBS-1:0] : wr_addr_q;
			hrdata_q <= rd_req ? rd_mux : hrdata_q;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boot_manage_off_q <= CTRL_RST;
			status_q <= STATUS_RST;
			mask_q <= MASK_RST;
			irq_q <= 1'b0;
		end else begin
			if (wr_ctrl) boot_manage_off_q <= hwdata_i[MANAGE_OFF_BIT];
			if (wr_mask) mask_q <= hwdata_i[2:0];
			status_q <= status_d;
			irq_q <= |(status_q & ~mask_q);
		end
	end

	// Forced low-side overrides the controller; its high-side is blocked
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gate_q <= '0;
		end else begin
			for (int p = 0; p < PHASES; p++) begin
				gate_q[p].ls <= gate_cmd_i[p].ls | force_w[p];
				gate_q[p].hs <= gate_cmd_i[p].hs & ~force_w[p];
			end
		end
	end

	assign hreadyout_o = hready_q;
	assign hresp_o = hresp_q;
	assign hrdata_o = hrdata_q;
	assign gate_drv_o = gate_q;
	assign irq_o = irq_q;

	logic [2:0] hs_w, ls_w;
	for (genvar p = 0; p < PHASES; p++) begin : g_view
		assign hs_w[p] = gate_q[p].hs;
		assign ls_w[p] = gate_q[p].ls;
	end

	// Forcing age on phase A, kept only so the recharge cover needs no long delay range
	localparam int COVER_SPAN_CYC = 2000;
	logic [CNT_W-1:0] force_age_q;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			force_age_q <= '0;
		end else begin
			force_age_q <= force_w[0] ? force_age_q + CNT_W'(force_age_q != '1) : '0;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	cross_block_a: assert property (force_w != 3'h0 |=> (hs_w & $past(force_w)) == 3'h0
		&& (ls_w & $past(force_w)) == $past(force_w))
		else $error("high-side on while low-side forced");
	monitor_entry_a: assert property (below_uv_i[0] && !charging_w[0] |=> charging_w[0])
		else $error("phase A undervoltage not tracked");
	hold_charge_a: assert property (charging_w[1] && !above_hys_i[1] |=> charging_w[1])
		else $error("recharge ended before recovery");
	min_time_a: assert property ($fell(charging_w[0]) |->
		$past(cnt_w[0]) >= CNT_W'(CHARGE_MIN_CYC - 1))
		else $error("recharge shorter than minimum");
	fault_time_a: assert property (fault_w[2] |-> $past(cnt_w[2]) ==
		CNT_W'(FAULT_TIMEOUT_CYC - 1) && $past(charging_w[2]))
		else $error("fault at wrong time");
	disable_drive_a: assert property (boot_manage_off_q |-> force_w == 3'h0)
		else $error("forcing while management off");
	monitor_off_a: assert property (boot_manage_off_q && below_uv_i[2] && !charging_w[2]
		|=> charging_w[2])
		else $error("monitoring stopped while management off");

	force_enable_a: assert property (charging_w[0] && !boot_manage_off_q
		|-> force_w[0])
		else $error("recharge not forced while management on");

	// Gated by reset too, so the edge that releases reset is not judged
	gate_pass_a: assert property (rst_n_i && force_w == 3'h0
		|=> gate_q == $past(gate_cmd_i))
		else $error("controller command not passed through");

	exit_recovery_a: assert property ($fell(charging_w[1])
		|-> $past(above_hys_i[1]))
		else $error("recharge ended without recovery");

	exit_min_a: assert property ($fell(charging_w[2])
		|-> $past(cnt_w[2]) >= CNT_W'(CHARGE_MIN_CYC - 1))
		else $error("phase C recharge shorter than minimum");

	fault_pulse_a: assert property (fault_w[2]
		|=> !fault_w[2])
		else $error("fault repeated within one interval");

	no_fault_idle_a: assert property (!charging_w[0]
		|=> !fault_w[0])
		else $error("fault raised outside recharge");

	ctrl_write_a: assert property (wr_ctrl
		|=> boot_manage_off_q == $past(hwdata_i[MANAGE_OFF_BIT]))
		else $error("control bit not written");
	ctrl_read_a: assert property (rd_req && rd_addr == CTRL_ADDR
		|=> hrdata_q == {31'h0, $past(boot_manage_off_q)})
		else $error("control bit read wrong");

	// Mask gates only the interrupt; the sticky flags keep recording
	status_set_a: assert property (fault_w[1]
		|=> status_q[1] ##1 (irq_q || $past(mask_q[1])))
		else $error("fault flag not set");
	status_hold_a: assert property (status_q[1] && !(wr_status && hwdata_i[1])
		|=> status_q[1])
		else $error("fault flag lost without clear");
	status_clear_a: assert property (wr_status && (fault_w & hwdata_i[2:0]) == 3'h0
		|=> (status_q & $past(hwdata_i[2:0])) == 3'h0)
		else $error("fault flag not cleared");

	mask_read_a: assert property (rd_req && rd_addr == MASK_ADDR
		|=> hrdata_q == {29'h0, $past(mask_q)})
		else $error("mask read wrong");

	irq_level_a: assert property ((status_q & ~mask_q) != 3'h0 |=> irq_q)
		else $error("interrupt missing");
	irq_quiet_a: assert property ((status_q & ~mask_q) == 3'h0 |=> !irq_q)
		else $error("interrupt without unmasked fault");

	recharge_c: cover property ($fell(force_w[0]) && $past(force_age_q) < CNT_W'(COVER_SPAN_CYC));
	fault_c: cover property (fault_w[1] ##1 irq_q);
	disabled_c: cover property (boot_manage_off_q && charging_w[2]);
	fault_off_c: cover property (fault_w[2] && boot_manage_off_q);
	clear_c: cover property (wr_status && status_q != 3'h0);
endmodule // bootstrap_charge_manager
`default_nettype wire

/* File: verif/boot_ctrl_model.sv */
`default_nettype none
module boot_ctrl_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [1:0] mode_i,
	output boot_pkg::gate_pair_t [2:0] gate_cmd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] step_q;
	// Commutation must keep turning or regenerative braking stops
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_q <= 3'h1;
		end else begin
			step_q <= {step_q[1:0], step_q[2]};
		end
	end
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			case (mode_i)
				2'h1: gate_cmd_o[p] = 2'h1;
				2'h2: gate_cmd_o[p] = 2'h2;
				2'h3: gate_cmd_o[p] = {step_q[p], step_q[(p + 1) % 3]};
				default: gate_cmd_o[p] = 2'h0;
			endcase
		end
	end
endmodule // boot_ctrl_model
`default_nettype wire

/* File: verif/tb_bootstrap_charge_manager.sv */
`default_nettype none
module tb_bootstrap_charge_manager;
	timeunit 1ns;
	timeprecision 1ps;
	import boot_pkg::*;
	localparam int TO_CYC = 3000;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0, mode = 2'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [2:0] below = 3'h0, above = 3'h7;
	logic hrdy, hresp, irq;
	logic [31:0] hrdata;
	gate_pair_t [2:0] cmd, drv;
	int errors = 0, compares = 0, cyc = 0;
	always #2.5 clk = ~clk;
	bootstrap_charge_manager #(.FAULT_TIMEOUT_CYC(TO_CYC)) bootstrap_charge_manager_i (
		.clk_sys_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
		.below_uv_i(below), .above_hys_i(above), .gate_cmd_i(cmd), .gate_drv_o(drv),
		.irq_o(irq));
	boot_ctrl_model boot_ctrl_model_i (.clk_sys_i(clk), .rst_n_i(rst_n), .mode_i(mode),
		.gate_cmd_o(cmd));
	task summarize;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize();
		end
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= 32'(a); hwrite <= wr;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, exp, rd);
		chk("hresp", 32'h0, 32'(hresp));
	endtask
	task pulse(input logic [2:0] ph, input logic [2:0] ab);
		@(posedge clk);
		above <= ab; below <= ph;
		@(posedge clk);
		below <= 3'h0;
	endtask
	task t_regs;
		rchk("ctrl", CTRL_ADDR, 32'h0);
		rchk("status", STATUS_ADDR, 32'h0);
		rchk("mask", MASK_ADDR, 32'h0);
		bus(1'b1, 4'h0, 32'h1);
		rchk("ctrl_wr", CTRL_ADDR, 32'h1);
		bus(1'b1, 4'h0, 32'h0);
	endtask
	task t_charge;
		int n;
		n = 0;
		pulse(3'h1, 3'h7);
		for (int i = 0; i < 1600; i++) begin
			@(negedge clk);
			if (drv[0].ls === 1'b1) n++;
			if (i == 5) chk("force", 32'h29, 32'(drv));
		end
		chk("charge_len", 32'h1, 32'(n >= CHARGE_MIN_CYC && n <= CHARGE_MIN_CYC + 2));
		chk("released", 32'h2A, 32'(drv));
	endtask
	task t_fault(input logic off, input logic [2:0] ph);
		bus(1'b1, CTRL_ADDR, 32'(off));
		pulse(ph, ~ph);
		repeat (5) @(negedge clk);
		chk("gate", off ? 32'h2A : 32'h2A ^ (32'(ph) * 32'(ph) * 32'h3), 32'(drv));
		rchk("state", STATE_ADDR, off ? 32'(ph) : 32'(ph) * 32'h9);
		repeat (TO_CYC + 10) @(negedge clk);
		chk("irq", 32'h1, 32'(irq));
		rchk("status", STATUS_ADDR, 32'(ph));
		bus(1'b1, MASK_ADDR, 32'(ph));
		repeat (2) @(negedge clk);
		chk("irq_masked", 32'h0, 32'(irq));
		bus(1'b1, STATUS_ADDR, 32'(ph));
		rchk("cleared", STATUS_ADDR, 32'h0);
		bus(1'b1, MASK_ADDR, 32'h0);
		bus(1'b1, CTRL_ADDR, 32'h0);
		pulse(3'h0, 3'h7);
	endtask
	task t_brake;
		gate_pair_t [2:0] prev;
		@(posedge clk);
		mode <= 2'h1;
		repeat (3) @(negedge clk);
		chk("brake_low", 32'h15, 32'(drv));
		@(posedge clk);
		mode <= 2'h3;
		@(negedge clk);
		for (int i = 0; i < 6; i++) begin
			prev = cmd;
			@(negedge clk);
			chk("regen", 32'(prev), 32'(drv));
		end
		@(posedge clk);
		mode <= 2'h2;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs();
		t_charge();
		t_fault(1'b0, 3'h2);
		t_fault(1'b1, 3'h4);
		t_brake();
		summarize();
	end
endmodule // tb_bootstrap_charge_manager
`default_nettype wire
